// ---- rszow_line_addr.sv ----
// Circular line pointer and line start address generator
`timescale 1ns/1ps
`default_nettype none
module rszow_line_addr
  import rszow_pkg::*;
#(
  parameter int AW = RSZOW_AW
) (
  // Clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // Events
  input  wire logic          frame_start,
  input  wire logic          line_done,
  // Setup
  input  wire logic          rgb,
  input  wire logic [AW-1:0] base,
  input  wire logic [AW-1:0] first,
  input  wire logic [15:0]   pitch,
  input  wire logic [15:0]   rgb_pitch,
  input  wire logic [12:0]   ptr_first,
  input  wire logic [12:0]   cap,
  // Current line
  output logic [AW-1:0]      line_addr,
  output logic [12:0]        ptr
);
  logic [AW-1:0] pitch_eff;

  // Packed lines in RGB mode; pitch low bits dropped
  always_comb begin
    if (rgb)
      pitch_eff = AW'(rgb_pitch);
    else
      pitch_eff = AW'({pitch[15:RSZOW_PITCH_LSB], 5'h00});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_addr <= '0;
      ptr       <= 13'h0000;
    end else if (frame_start) begin
      line_addr <= first;
      ptr       <= ptr_first;
    end else if (line_done) begin
      if (ptr >= cap) begin
        line_addr <= base;
        ptr       <= 13'h0000;
      end else begin
        line_addr <= line_addr + pitch_eff;
        ptr       <= ptr + 13'h0001;
      end
    end
  end

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    line_done && !frame_start && ptr >= cap
      |=> ptr == 13'h0000 && line_addr == $past(base);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("line pointer did not wrap to base");

  property p_step;
    @(posedge hclk) disable iff (!hresetn)
    line_done && !frame_start && ptr < cap
      |=> line_addr == $past(line_addr) + $past(pitch_eff);
  endproperty
  a_step: assert property (p_step)
    else $error("line address did not step by pitch");

  property p_align;
    @(posedge hclk) disable iff (!hresetn)
    line_done && !frame_start && !rgb && ptr < cap
      |=> line_addr[4:0] == $past(line_addr[4:0]);
  endproperty
  a_align: assert property (p_align)
    else $error("pitch not a multiple of 32");
endmodule : rszow_line_addr
`default_nettype wire

// ---- rszow_mem_model.sv ----
// Memory side model: accepts write beats, optionally with back-pressure
`timescale 1ns/1ps
`default_nettype none
module rszow_mem_model
  import rszow_pkg::*;
(
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Write handshake
  output logic      wr_ready,
  // Stall control
  input  wire logic slow
);
  logic [1:0] cnt;

  // Slow mode accepts one beat in four, like a busy interconnect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt      <= 2'h0;
      wr_ready <= 1'b0;
    end else begin
      cnt      <= cnt + 2'h1;
      wr_ready <= !slow || (cnt == 2'h3);
    end
  end
endmodule : rszow_mem_model
`default_nettype wire

// ---- rszow_pixel_conv.sv ----
// Pixel formatter: YC pass-through, ARGB 8888 or RGB 565
`timescale 1ns/1ps
`default_nettype none
module rszow_pixel_conv
  import rszow_pkg::*;
(
  // Pixel and format
  input  wire rszow_pix_t pix,
  input  wire logic       odd,
  input  wire rszow_fmt_t fmt,
  // Formatted word
  output logic [31:0]     data,
  output logic            wide
);
  function automatic logic [7:0] clamp8(input logic signed [17:0] v);
    if (v < 18'sh00000)
      return 8'h00;
    else if (v > 18'sh000ff)
      return 8'hff;
    return v[7:0];
  endfunction : clamp8

  logic signed [17:0] yy;
  logic signed [17:0] cbs;
  logic signed [17:0] crs;
  logic [7:0]         r;
  logic [7:0]         g;
  logic [7:0]         b;

  always_comb begin
    yy  = $signed({10'h000, pix.y});
    cbs = $signed({10'h000, pix.cb}) - RSZOW_MID;
    crs = $signed({10'h000, pix.cr}) - RSZOW_MID;
    r = clamp8(yy + ((RSZOW_K_RV * crs) >>> 8));
    g = clamp8(yy - ((RSZOW_K_GU * cbs + RSZOW_K_GV * crs) >>> 8));
    b = clamp8(yy + ((RSZOW_K_BU * cbs) >>> 8));
    wide = fmt.rgb && !fmt.narrow;
    if (!fmt.rgb)
      data = {16'h0000, odd ? pix.cr : pix.cb, pix.y};
    else if (fmt.narrow)
      data = {16'h0000, r[7:3], g[7:2], b[7:3]};
    else
      data = {fmt.alpha, r, g, b};
  end
endmodule : rszow_pixel_conv
`default_nettype wire

// ---- rszow_pkg.sv ----
// Shared constants and types for the resizer output writer
package rszow_pkg;
  localparam int RSZOW_AW = 28;
  // Register byte offsets
  localparam logic [7:0] RSZOW_LSE   = 8'h00;
  localparam logic [7:0] RSZOW_LPF   = 8'h04;
  localparam logic [7:0] RSZOW_RGBEN = 8'h08;
  localparam logic [7:0] RSZOW_TYP   = 8'h0c;
  localparam logic [7:0] RSZOW_ALPHA = 8'h10;
  localparam logic [7:0] RSZOW_BADH  = 8'h14;
  localparam logic [7:0] RSZOW_BADL  = 8'h18;
  localparam logic [7:0] RSZOW_SADH  = 8'h1c;
  localparam logic [7:0] RSZOW_SADL  = 8'h20;
  localparam logic [7:0] RSZOW_OFT   = 8'h24;
  localparam logic [7:0] RSZOW_PTRS  = 8'h28;
  localparam logic [7:0] RSZOW_PTRE  = 8'h2c;
  localparam logic [7:0] RSZOW_PTRO  = 8'h30;
  localparam logic [7:0] RSZOW_BOX   = 8'h34;
  // Field positions in the format and mask register
  localparam int RSZOW_TYP_NARROW = 0;
  localparam int RSZOW_TYP_LEAD   = 1;
  localparam int RSZOW_TYP_TRAIL  = 2;
  // Reset values and counts
  localparam logic [12:0] RSZOW_CAP_RST  = 13'h1fff;
  localparam int          RSZOW_PITCH_LSB = 5;
  localparam logic [1:0]  RSZOW_MASK_PIX = 2'h2;
  localparam logic [15:0] RSZOW_STEP_WIDE = 16'h0004;
  localparam logic [15:0] RSZOW_STEP_NARW = 16'h0002;
  localparam logic [15:0] RSZOW_ROUND32   = 16'h001f;
  // Colour conversion, scaled by 256
  localparam logic signed [17:0] RSZOW_MID  = 18'sh00080;
  localparam logic signed [17:0] RSZOW_K_RV = 18'sh00167;
  localparam logic signed [17:0] RSZOW_K_GU = 18'sh00058;
  localparam logic signed [17:0] RSZOW_K_GV = 18'sh000b7;
  localparam logic signed [17:0] RSZOW_K_BU = 18'sh001c6;
  typedef enum logic {RSZOW_BUS_IDLE, RSZOW_BUS_RDWAIT} rszow_bus_t;
  typedef struct packed {
    logic       sof;
    logic       sol;
    logic       eol;
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
  } rszow_pix_t;
  typedef struct packed {
    logic [RSZOW_AW-1:0] addr;
    logic [31:0]         data;
    logic                wide;
  } rszow_wr_t;
  typedef struct packed {
    logic        rgb;
    logic        narrow;
    logic [7:0]  alpha;
  } rszow_fmt_t;
  typedef struct packed {
    logic [31:0] data;
    logic        wide;
    logic        keep;
    logic        eol;
  } rszow_ent_t;
endpackage : rszow_pkg

// ---- rszow_writer.sv ----
// Resizer output writer: AHB-Lite registers, formatter, line writer
// Notes on behaviour
// - Source select 0 uses internal lowpass strength
// - Source select 1 uses programmed 8-bit strength
// - RGB conversion only while enable bit set
// - Width bit: 0 gives ARGB8888, 1 RGB565
// - Leading mask drops first two pixels per line
// - Trailing mask drops last two pixels per line
// - Programmed alpha fills every 32-bit pixel
// - Region base is upper field plus low half
// - First write address from upper and low halves
// - Line n written at start plus n pitches
// - Pitch low five bits forced to zero
// - Programmed pitch ignored in RGB mode
// - First line at programmed 13-bit position
// - Past capacity, next line restarts at base
// - Read-only position of last written line, recorded only while RGB is disabled
// - Boxcar sampling runs only while enabled
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module rszow_writer
  import rszow_pkg::*;
#(
  parameter int AW = RSZOW_AW
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Resized pixel stream in
  input  wire logic        pix_valid,
  input  wire rszow_pix_t  pix,
  output logic             pix_ready,
  // Memory write beats out
  output logic             wr_valid,
  output rszow_wr_t        wr,
  input  wire logic        wr_ready,
  // Filter and boxcar controls
  input  wire logic [7:0]  lpf_internal,
  output logic [7:0]       lpf_intensity,
  output logic             boxcar_run
);
  // Registers
  logic        lse;
  logic [7:0]  lpf;
  logic        rgb_en;
  logic [2:0]  output_width_choice;
  logic [7:0]  alpha;
  logic [11:0] bad_h;
  logic [15:0] bad_l;
  logic [11:0] sad_h;
  logic [15:0] sad_l;
  logic [15:0] pitch_field;
  logic [12:0] ptr_s;
  logic [12:0] ptr_e;
  logic [12:0] ptr_o;
  logic        boxcar_enable;

  // Bus state
  rszow_bus_t  state;
  logic        take;
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic [7:0]  rd_ofs;
  logic [31:0] rd_word;

  // Stream state
  rszow_ent_t  ent [2];
  rszow_ent_t  next_ent [2];
  rszow_ent_t  new_ent;
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic        flush;
  logic        next_flush;
  logic        avail;
  logic        out_free;
  logic        pop;
  logic        push;
  logic        trail;
  logic [1:0]  lead_cnt;
  logic [1:0]  lead_idx;
  logic        par;
  logic        odd;
  logic [15:0] byte_off;
  logic [15:0] step;
  logic [15:0] line_bytes;
  logic [15:0] rgb_pitch;
  logic        line_done;
  logic        frame_start;
  rszow_fmt_t  fmt;
  logic [31:0] conv_data;
  logic        conv_wide;
  logic [AW-1:0] line_addr;
  logic [12:0]   ptr;

  // Single-word transfers only; hsize is not checked
  assign take = hsel && htrans[1] && hready;

  // Reads take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= RSZOW_BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      rd_ofs    <= 8'h00;
    end else begin
      case (state)
        RSZOW_BUS_IDLE: begin
          if (take && !hwrite) begin
            state     <= RSZOW_BUS_RDWAIT;
            hreadyout <= 1'b0;
            rd_ofs    <= haddr[7:0];
          end
        end
        RSZOW_BUS_RDWAIT: begin
          hrdata    <= rd_word;
          hreadyout <= 1'b1;
          state     <= RSZOW_BUS_IDLE;
        end
        default: state <= RSZOW_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
      hresp   <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      wr_ofs  <= haddr[7:0];
      hresp   <= 1'b0;
    end
  end

  // Unmapped offsets read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_ofs == RSZOW_LSE)
      rd_word[0] = lse;
    else if (rd_ofs == RSZOW_LPF)
      rd_word[7:0] = lpf;
    else if (rd_ofs == RSZOW_RGBEN)
      rd_word[0] = rgb_en;
    else if (rd_ofs == RSZOW_TYP)
      rd_word[2:0] = output_width_choice;
    else if (rd_ofs == RSZOW_ALPHA)
      rd_word[7:0] = alpha;
    else if (rd_ofs == RSZOW_BADH)
      rd_word[11:0] = bad_h;
    else if (rd_ofs == RSZOW_BADL)
      rd_word[15:0] = bad_l;
    else if (rd_ofs == RSZOW_SADH)
      rd_word[11:0] = sad_h;
    else if (rd_ofs == RSZOW_SADL)
      rd_word[15:0] = sad_l;
    else if (rd_ofs == RSZOW_OFT)
      rd_word[15:0] = pitch_field;
    else if (rd_ofs == RSZOW_PTRS)
      rd_word[12:0] = ptr_s;
    else if (rd_ofs == RSZOW_PTRE)
      rd_word[12:0] = ptr_e;
    else if (rd_ofs == RSZOW_PTRO)
      rd_word[12:0] = ptr_o;
    else if (rd_ofs == RSZOW_BOX)
      rd_word[0] = boxcar_enable;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lse    <= 1'b0;
      lpf    <= 8'h00;
      rgb_en <= 1'b0;
      output_width_choice    <= 3'h0;
      alpha  <= 8'h00;
      bad_h  <= 12'h000;
      bad_l  <= 16'h0000;
      sad_h  <= 12'h000;
      sad_l  <= 16'h0000;
      pitch_field    <= 16'h0000;
      ptr_s  <= 13'h0000;
      ptr_e  <= RSZOW_CAP_RST;
      boxcar_enable <= 1'b0;
    end else if (wr_pend) begin
      if (wr_ofs == RSZOW_LSE)
        lse <= hwdata[0];
      else if (wr_ofs == RSZOW_LPF)
        lpf <= hwdata[7:0];
      else if (wr_ofs == RSZOW_RGBEN)
        rgb_en <= hwdata[0];
      else if (wr_ofs == RSZOW_TYP)
        output_width_choice <= hwdata[2:0];
      else if (wr_ofs == RSZOW_ALPHA)
        alpha <= hwdata[7:0];
      else if (wr_ofs == RSZOW_BADH)
        bad_h <= hwdata[11:0];
      else if (wr_ofs == RSZOW_BADL)
        bad_l <= hwdata[15:0];
      else if (wr_ofs == RSZOW_SADH)
        sad_h <= hwdata[11:0];
      else if (wr_ofs == RSZOW_SADL)
        sad_l <= hwdata[15:0];
      else if (wr_ofs == RSZOW_OFT)
        pitch_field <= {hwdata[15:RSZOW_PITCH_LSB], 5'h00};
      else if (wr_ofs == RSZOW_PTRS)
        ptr_s <= hwdata[12:0];
      else if (wr_ofs == RSZOW_PTRE)
        ptr_e <= hwdata[12:0];
      else if (wr_ofs == RSZOW_BOX)
        boxcar_enable <= hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lpf_intensity <= 8'h00;
      boxcar_run    <= 1'b0;
    end else begin
      lpf_intensity <= lse ? lpf : lpf_internal;
      boxcar_run    <= boxcar_enable;
    end
  end

  assign fmt = '{rgb: rgb_en, narrow: output_width_choice[RSZOW_TYP_NARROW], alpha: alpha};
  assign odd = pix.sol ? 1'b0 : par;

  rszow_pixel_conv u_conv (
    .pix  (pix),
    .odd  (odd),
    .fmt  (fmt),
    .data (conv_data),
    .wide (conv_wide)
  );

  // Two-entry hold: the trailing pair is only known at line end
  always_comb begin
    next_ent   = ent;
    next_cnt   = cnt;
    next_flush = flush;
    avail    = (cnt == 2'h2) || (cnt != 2'h0 && flush);
    out_free = !wr_valid || wr_ready;
    pop      = avail && (!ent[0].keep || out_free);
    push     = pix_valid && pix_ready;
    lead_idx = pix.sol ? 2'h0 : lead_cnt;
    trail    = rgb_en && output_width_choice[RSZOW_TYP_TRAIL] && pix.eol;
    new_ent.data = conv_data;
    new_ent.wide = conv_wide;
    new_ent.eol  = pix.eol;
    new_ent.keep = !(rgb_en && output_width_choice[RSZOW_TYP_LEAD]
                     && lead_idx < RSZOW_MASK_PIX) && !trail;
    if (pop) begin
      next_ent[0] = ent[1];
      next_cnt    = cnt - 2'h1;
      if (ent[0].eol)
        next_flush = 1'b0;
    end
    if (push) begin
      if (trail && next_cnt == 2'h1)
        next_ent[0].keep = 1'b0;
      next_ent[next_cnt[0]] = new_ent;
      next_cnt = next_cnt + 2'h1;
      if (pix.eol)
        next_flush = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ent       <= '{default: '0};
      cnt       <= 2'h0;
      flush     <= 1'b0;
      pix_ready <= 1'b1;
    end else begin
      ent       <= next_ent;
      cnt       <= next_cnt;
      flush     <= next_flush;
      pix_ready <= (next_cnt < 2'h2) && !next_flush;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lead_cnt <= 2'h0;
      par      <= 1'b0;
    end else if (push) begin
      lead_cnt <= (lead_idx < RSZOW_MASK_PIX) ? lead_idx + 2'h1 : lead_idx;
      par      <= !odd;
    end
  end

  assign step = !ent[0].keep ? 16'h0000
              : ent[0].wide ? RSZOW_STEP_WIDE : RSZOW_STEP_NARW;
  assign line_bytes  = byte_off + step;
  // Rounded from the line just ending, so the next line starts past that line's size
  assign rgb_pitch   = (line_bytes + RSZOW_ROUND32) & ~RSZOW_ROUND32;
  assign line_done   = pop && ent[0].eol;
  assign frame_start = push && pix.sof;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_valid <= 1'b0;
      wr       <= '0;
    end else if (pop && ent[0].keep) begin
      wr_valid <= 1'b1;
      wr.addr  <= line_addr + AW'(byte_off);
      wr.data  <= ent[0].data;
      wr.wide  <= ent[0].wide;
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end

  // Packed RGB lines start on 32-byte boundaries
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_off  <= 16'h0000;
      ptr_o     <= 13'h0000;
    end else if (line_done) begin
      byte_off  <= 16'h0000;
      if (!rgb_en)
        ptr_o <= ptr;
    end else if (pop) begin
      byte_off <= line_bytes;
    end
  end

  rszow_line_addr #(
    .AW (AW)
  ) u_line (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .frame_start (frame_start),
    .line_done   (line_done),
    .rgb         (rgb_en),
    .base        (AW'({bad_h, bad_l})),
    .first       (AW'({sad_h, sad_l})),
    .pitch       (pitch_field),
    .rgb_pitch   (rgb_pitch),
    .ptr_first   (ptr_s),
    .cap         (ptr_e),
    .line_addr   (line_addr),
    .ptr         (ptr)
  );

  property p_lpf_int;
    @(posedge hclk) disable iff (!hresetn)
    !lse |=> lpf_intensity == $past(lpf_internal);
  endproperty
  a_lpf_int: assert property (p_lpf_int)
    else $error("internal lowpass strength not used");

  property p_lpf_reg;
    @(posedge hclk) disable iff (!hresetn)
    lse ##1 lse |-> lpf_intensity == $past(lpf);
  endproperty
  a_lpf_reg: assert property (p_lpf_reg)
    else $error("programmed lowpass strength not used");

  property p_yc;
    @(posedge hclk) disable iff (!hresetn)
    !rgb_en |-> !conv_wide && conv_data[31:16] == 16'h0000
                && conv_data[7:0] == pix.y;
  endproperty
  a_yc: assert property (p_yc)
    else $error("RGB output while disabled");

  property p_argb;
    @(posedge hclk) disable iff (!hresetn)
    rgb_en && !output_width_choice[RSZOW_TYP_NARROW]
      |-> conv_wide && conv_data[31:24] == alpha;
  endproperty
  a_argb: assert property (p_argb)
    else $error("alpha missing from 32-bit pixel");

  property p_565;
    @(posedge hclk) disable iff (!hresetn)
    rgb_en && output_width_choice[RSZOW_TYP_NARROW]
      |-> !conv_wide && conv_data[31:16] == 16'h0000;
  endproperty
  a_565: assert property (p_565)
    else $error("16-bit pixel wider than 16 bits");

  property p_lead;
    @(posedge hclk) disable iff (!hresetn)
    push && pix.sol && rgb_en && output_width_choice[RSZOW_TYP_LEAD] && !pop
      |=> !ent[cnt[0] - 1'b1].keep;
  endproperty
  a_lead: assert property (p_lead)
    else $error("leading pixel not masked");

  property p_ptr_o;
    @(posedge hclk) disable iff (!hresetn)
    line_done && !rgb_en |=> ptr_o == $past(ptr);
  endproperty
  a_ptr_o: assert property (p_ptr_o)
    else $error("last line position not recorded");

  property p_box;
    @(posedge hclk) disable iff (!hresetn)
    !boxcar_enable |=> !boxcar_run;
  endproperty
  a_box: assert property (p_box)
    else $error("boxcar running while disabled");

  property p_rdwait;
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rdwait: assert property (p_rdwait)
    else $error("read wait state wrong");
endmodule : rszow_writer
`default_nettype wire

// ---- rszow_writer_bench.sv ----
// Self-checking bench for the resizer output writer
`timescale 1ns/1ps
`default_nettype none
module rszow_writer_bench;
  import rszow_pkg::*;
  typedef struct packed {
    logic [27:0] a;
    logic [31:0] d;
    logic        w;
    logic        ca;
  } rszow_bexp_t;
  localparam logic [7:0] ALPHA = 8'h5a;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        pix_valid, pix_ready, wr_valid, wr_ready, boxcar_run, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [7:0]  lpf_internal, lpf_intensity, li;
  logic [15:0] rnd;
  rszow_pix_t  pix;
  rszow_wr_t   wr;
  rszow_bexp_t expq[$];
  rszow_bexp_t ex;
  int          num_errors, checks, cyc;

  rszow_writer rszow_writer_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pix_valid(pix_valid), .pix(pix),
    .pix_ready(pix_ready), .wr_valid(wr_valid), .wr(wr),
    .wr_ready(wr_ready), .lpf_internal(lpf_internal),
    .lpf_intensity(lpf_intensity), .boxcar_run(boxcar_run));
  rszow_mem_model rszow_mem_model_inst (
    .hclk(hclk), .hresetn(hresetn), .wr_ready(wr_ready), .slow(slow));

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : step

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Holds each phase until hready is seen high at the edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic settle();
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  task automatic px(input logic f, s, e, input logic [7:0] y, cb, cr);
    pix_valid <= 1'b1;
    pix       <= '{f, s, e, y, cb, cr};
    do @(negedge hclk); while (pix_ready !== 1'b1);
    @(posedge hclk);
  endtask : px

  // Mode 0 YC, 1 ARGB, 2 RGB565 with both edge pairs dropped
  task automatic line(input logic f, input int n, input int m,
                      input logic [27:0] la);
    logic [7:0]  y;
    logic [7:0]  c;
    rszow_bexp_t e;
    for (int i = 0; i < n; i++) begin
      rnd = step(rnd);
      y = rnd[7:0];
      c = (m == 0) ? rnd[15:8] : 8'h80;
      e.a = la + 28'(i * ((m == 1) ? 4 : 2));
      e.w = (m == 1);
      e.ca = (m != 2);
      e.d = (m == 1) ? {ALPHA, y, y, y} :
            (m == 2) ? {16'h0, y[7:3], y[7:2], y[7:3]} :
            {16'h0, i[0] ? ~c : c, y};
      if (m != 2 || (i >= 2 && i < n - 2))
        expq.push_back(e);
      px(f && i == 0, i == 0, i == n - 1, y, c, (m == 0) ? ~c : c);
    end
  endtask : line

  // Grey pixels keep colour checks exact whatever the rounding
  task automatic drain();
    pix_valid <= 1'b0;
    while (expq.size() != 0)
      @(posedge hclk);
    repeat (4) @(posedge hclk);
  endtask : drain

  always @(negedge hclk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      if (expq.size() == 0) begin
        chk("beat count", 32'h0, 32'h1);
      end else begin
        ex = expq.pop_front();
        chk("beat wide", {31'h0, ex.w}, {31'h0, wr.wide});
        if (ex.ca)
          chk("beat addr", {4'h0, ex.a}, {4'h0, wr.addr});
        chk("beat data", ex.d & (ex.w ? 32'hffffffff : 32'hffff),
            wr.data & (ex.w ? 32'hffffffff : 32'hffff));
      end
    end
  end

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, pix_valid, slow} = 5'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    pix = '0;
    lpf_internal = 8'h0;
    rnd = 16'h7f97;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 15; i++)
      rchk("reset value", 8'(i * 4), (i == 11) ? 32'h1fff : 32'h0);
    $display("test reset values done");
    rnd = step(rnd);
    li = rnd[7:0];
    lpf_internal <= li;
    bus(1'b1, RSZOW_LPF, 32'hc3);
    settle();
    chk("lpf internal", {24'h0, li}, {24'h0, lpf_intensity});
    bus(1'b1, RSZOW_LSE, 32'h1);
    settle();
    chk("lpf programmed", 32'hc3, {24'h0, lpf_intensity});
    for (int b = 1; b >= 0; b--) begin
      bus(1'b1, RSZOW_BOX, 32'(b));
      settle();
      chk("boxcar", 32'(b), {31'h0, boxcar_run});
    end
    $display("test filter and boxcar done");
    bus(1'b1, RSZOW_BADH, 32'h0ab);
    bus(1'b1, RSZOW_BADL, 32'h1000);
    bus(1'b1, RSZOW_SADH, 32'h0ab);
    bus(1'b1, RSZOW_SADL, 32'h1000);
    bus(1'b1, RSZOW_OFT, 32'h45);
    bus(1'b1, RSZOW_PTRE, 32'h1);
    rchk("pitch", RSZOW_OFT, 32'h40);
    slow <= 1'b1;
    for (int l = 0; l < 4; l++)
      line(l == 0, 2, 0, 28'h0ab1000 + (l[0] ? 28'h40 : 28'h0));
    drain();
    rchk("last line", RSZOW_PTRO, 32'h1);
    bus(1'b1, RSZOW_PTRO, 32'h5);
    rchk("last line ro", RSZOW_PTRO, 32'h1);
    $display("test yc lines done");
    slow <= 1'b0;
    bus(1'b1, RSZOW_PTRE, 32'h4);
    bus(1'b1, RSZOW_RGBEN, 32'h1);
    bus(1'b1, RSZOW_ALPHA, {24'h0, ALPHA});
    line(1'b1, 4, 1, 28'h0ab1000);
    line(1'b0, 4, 1, 28'h0ab1020);
    drain();
    bus(1'b1, RSZOW_TYP, 32'h7);
    line(1'b1, 6, 2, 28'h0);
    drain();
    $display("test rgb lines done");
    summarize();
  end
endmodule : rszow_writer_bench
`default_nettype wire
